// [src/lmi_cfg.svh]
/*
 * lmi_cfg.svh: register offsets, field positions, reset values and
 * timing counts for the led matrix intensity / configuration block.
 * Assumes it is included by bare name; definitions only.
 */
`ifndef LMI_CFG_SVH
`define LMI_CFG_SVH

// register offsets on the host register port
`define LMI_OFS_DIGIT_ZERO  8'h03
`define LMI_OFS_DIGIT_ONE   8'h04
`define LMI_OFS_PANEL_SETUP 8'h0D

// panel_setup field positions
`define LMI_BIT_PLANE_ORG   7
`define LMI_BIT_COLOUR      6
`define LMI_BIT_MUX_FLIP    5
`define LMI_BIT_RIPPLE      4
`define LMI_BIT_PLANE_HI    3
`define LMI_BIT_PLANE_LO    2
`define LMI_BIT_INVERT      1
`define LMI_BIT_SHUTDOWN    0

// reset values
`define LMI_RST_DIGIT       8'h00
`define LMI_RST_SETUP_BIT   1'b0

// twelve-frame modulation sequence, last index
`define LMI_FRAME_LAST      4'hB

// frame patterns, bit i = frame i
`define LMI_PAT_FULL        12'hFFF
`define LMI_PAT_ARITH_HI    12'hB6D
`define LMI_PAT_GEO_HI      12'h555
`define LMI_PAT_ARITH_LO    12'h492
`define LMI_PAT_GEO_LO      12'h222
`define LMI_PAT_OFF         12'h000

// clock and ripple stagger timing
`define LMI_CLK_PERIOD_PS   50000
`define LMI_STAGGER_PS      953700
`define LMI_STAGGER_CYC     (`LMI_STAGGER_PS / `LMI_CLK_PERIOD_PS)
`define LMI_TICK_DIV        8

`endif

// [src/lmi_pkg.sv]
/*
 * lmi_pkg.sv: types shared by the led matrix intensity block.
 * Assumes lmi_cfg.svh holds all numeric constants.
 */
package lmi_pkg;

  // pixel graduation for 2-bit pixel codes
  typedef enum logic [0:0] {
    LMI_GRAD_ARITH = 1'b0,
    LMI_GRAD_GEO   = 1'b1
  } lmi_grad_e;

  // stagger sequencer states
  typedef enum logic [1:0] {
    LMI_ST_RUN   = 2'b00,
    LMI_ST_DELAY = 2'b01,
    LMI_ST_HALT  = 2'b10
  } lmi_state_e;

  typedef logic [7:0] lmi_byte_t;

endpackage : lmi_pkg

// [src/lmi_core.sv]
/*
 * lmi_core.sv: panel configuration bits, digit intensity registers,
 * frame modulation of 2-bit pixel codes, digit pwm with ripple stagger
 * and mux flip. Assumes a host register port already decoded from the
 * serial link, and that the plane counter, panel intensity value and
 * multiplex sync pulse come from other logic on the same clock.
 */
`timescale 1ns/1ns
`include "lmi_cfg.svh"

module lmi_core #(
  parameter bit          HAS_RGY     = 1'b1,              // colour bit writable
  parameter bit          HAS_GREY    = 1'b1,              // plane bit writable
  parameter int unsigned TICK_DIV    = `LMI_TICK_DIV,     // clocks per pwm step
  parameter int unsigned STAGGER_CYC = `LMI_STAGGER_CYC   // clocks per driver step
) (
  input  wire logic       clock,
  input  wire logic       rst,
  // host register port
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // neighbouring logic
  input  wire logic [1:0] current_plane,    // plane counter output
  input  wire logic [7:0] panel_intensity,  // panel pwm value
  input  wire logic [7:0] driver_addr,      // auto-assigned address
  input  wire logic       mux_sync,         // start of multiplex cycle
  input  wire logic       mux_cycle_done,   // end of multiplex cycle
  input  wire logic [1:0] grad_geometric,   // per digit graduation
  input  wire logic [1:0] pix_code_d0,      // pixel code digit 0
  input  wire logic [1:0] pix_code_d1,      // pixel code digit 1
  // results
  output logic      [3:0] frame_index,      // modulation frame
  output logic            pixel_on_d0,      // pixel lit this frame
  output logic            pixel_on_d1,
  output logic            digit_drive_d0,   // final digit drive
  output logic            digit_drive_d1,
  output logic            plane_organisation_sel,
  output logic            invert_pixels,
  output logic            shutdown
);

  // setup fields
  logic       colour_rgy_r;      // 1 = rgy panel
  logic       mux_flip_r;        // flipped timing enable
  logic       ripple_r;          // ripple stagger enable
  logic       plane_org_r;       // 1 = two planes
  logic       invert_r;          // inverted display data
  logic       shutdown_r;        // multiplex halted
  lmi_pkg::lmi_byte_t digit0_r;  // digit zero intensity
  lmi_pkg::lmi_byte_t digit1_r;  // digit one intensity

  // write decode
  wire wr_digit0 = reg_wr_en && (reg_addr == `LMI_OFS_DIGIT_ZERO);
  wire wr_digit1 = reg_wr_en && (reg_addr == `LMI_OFS_DIGIT_ONE);
  wire wr_setup  = reg_wr_en && (reg_addr == `LMI_OFS_PANEL_SETUP);

  // feature-limited bits: a variant lacking the feature never stores a one
  wire colour_nxt = HAS_RGY  && reg_wdata[`LMI_BIT_COLOUR];
  wire porg_nxt   = HAS_GREY && reg_wdata[`LMI_BIT_PLANE_ORG];

  // setup register; plane id bits have no storage so writes vanish
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      colour_rgy_r <= `LMI_RST_SETUP_BIT;
      mux_flip_r   <= `LMI_RST_SETUP_BIT;
      ripple_r     <= `LMI_RST_SETUP_BIT;
      plane_org_r  <= `LMI_RST_SETUP_BIT;
      invert_r     <= `LMI_RST_SETUP_BIT;
      shutdown_r   <= `LMI_RST_SETUP_BIT;
    end else if (wr_setup) begin
      colour_rgy_r <= colour_nxt;
      plane_org_r  <= porg_nxt;
      mux_flip_r   <= reg_wdata[`LMI_BIT_MUX_FLIP];
      ripple_r     <= reg_wdata[`LMI_BIT_RIPPLE];
      invert_r     <= reg_wdata[`LMI_BIT_INVERT];
      shutdown_r   <= reg_wdata[`LMI_BIT_SHUTDOWN];
    end
  end

  // digit intensity registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      digit0_r <= `LMI_RST_DIGIT;
      digit1_r <= `LMI_RST_DIGIT;
    end else begin
      if (wr_digit0) digit0_r <= reg_wdata;
      if (wr_digit1) digit1_r <= reg_wdata;
    end
  end

  // plane id: two-plane mode reports planes 0/1 with the high code
  wire [1:0] plane_id = plane_org_r ? {1'b1, current_plane[0]}
                                    : current_plane;

  // read mux; unmapped offsets read zero
  wire [7:0] setup_rd = {plane_org_r, colour_rgy_r, mux_flip_r, ripple_r,
                         plane_id, invert_r, shutdown_r};
  always_comb begin
    case (reg_addr)
      `LMI_OFS_DIGIT_ZERO:  reg_rdata = digit0_r;
      `LMI_OFS_DIGIT_ONE:   reg_rdata = digit1_r;
      `LMI_OFS_PANEL_SETUP: reg_rdata = setup_rd;
      default:              reg_rdata = 8'h00;
    endcase
  end

  // frame index counter, one step per multiplex cycle
  logic [3:0] frame_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_r <= 4'h0;
    end else if (mux_cycle_done) begin
      frame_r <= (frame_r == `LMI_FRAME_LAST) ? 4'h0 : frame_r + 4'h1;
    end
  end

  // pattern lookup for one pixel code at the current frame
  function automatic logic frame_lit(input logic [1:0] code,
                                     input logic       geo,
                                     input logic       two_bit,
                                     input logic [3:0] frame);
    logic [11:0] pat;
    pat = `LMI_PAT_OFF;
    if (!two_bit) begin
      // one bit per pixel: plain on/off
      pat = code[0] ? `LMI_PAT_FULL : `LMI_PAT_OFF;
    end else begin
      case (code)
        2'b11:   pat = `LMI_PAT_FULL;
        2'b10:   pat = geo ? `LMI_PAT_GEO_HI : `LMI_PAT_ARITH_HI;
        2'b01:   pat = geo ? `LMI_PAT_GEO_LO : `LMI_PAT_ARITH_LO;
        default: pat = `LMI_PAT_OFF;
      endcase
    end
    frame_lit = pat[frame];
  endfunction : frame_lit

  // pixel decisions, registered so they are glitch free
  wire lit0 = frame_lit(pix_code_d0, grad_geometric[0], plane_org_r, frame_r);
  wire lit1 = frame_lit(pix_code_d1, grad_geometric[1], plane_org_r, frame_r);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pixel_on_d0 <= 1'b0;
      pixel_on_d1 <= 1'b0;
    end else begin
      pixel_on_d0 <= lit0 ^ invert_r;
      pixel_on_d1 <= lit1 ^ invert_r;
    end
  end

  // pwm step enable from the timebase divider
  logic [15:0] div_r;
  wire         tick = (div_r == 16'(TICK_DIV - 1));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) div_r <= 16'h0000;
    else     div_r <= tick ? 16'h0000 : div_r + 16'h0001;
  end

  // stagger: address times one step, capped by 255 steps (within 244 us)
  wire [15:0] stagger_load = 16'(driver_addr * STAGGER_CYC);

  // sequencer: halt in shutdown, delay after sync, then run the pwm
  lmi_pkg::lmi_state_e state_r;
  logic [15:0]         delay_r;
  logic [7:0]          pwm_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= lmi_pkg::LMI_ST_HALT;
      delay_r <= 16'h0000;
      pwm_r   <= 8'h00;
    end else begin
      case (state_r)
        lmi_pkg::LMI_ST_HALT: begin
          // multiplexing stopped; wait for a sync once awake
          pwm_r <= 8'h00;
          if (!shutdown_r && mux_sync) begin
            delay_r <= ripple_r ? stagger_load : 16'h0000;
            state_r <= lmi_pkg::LMI_ST_DELAY;
          end
        end
        lmi_pkg::LMI_ST_DELAY: begin
          // hold the cycle start back by this driver's stagger
          if (shutdown_r) begin
            state_r <= lmi_pkg::LMI_ST_HALT;
          end else if (delay_r == 16'h0000) begin
            pwm_r   <= 8'h00;
            state_r <= lmi_pkg::LMI_ST_RUN;
          end else begin
            delay_r <= delay_r - 16'h0001;
          end
        end
        lmi_pkg::LMI_ST_RUN: begin
          // a fresh sync restarts the stagger so neighbours stay spread
          if (shutdown_r) begin
            state_r <= lmi_pkg::LMI_ST_HALT;
          end else if (mux_sync) begin
            delay_r <= ripple_r ? stagger_load : 16'h0000;
            state_r <= lmi_pkg::LMI_ST_DELAY;
          end else if (tick) begin
            pwm_r <= pwm_r + 8'h01;
          end
        end
        default: state_r <= lmi_pkg::LMI_ST_HALT;
      endcase
    end
  end

  // digit duty is its fraction of the panel value; product top byte
  function automatic logic [7:0] scale_duty(input logic [7:0] n,
                                            input logic [7:0] panel);
    logic [15:0] prod;
    prod       = n * panel;
    scale_duty = prod[15:8];
  endfunction : scale_duty

  wire [7:0] duty0 = scale_duty(digit0_r, panel_intensity);
  wire [7:0] duty1 = scale_duty(digit1_r, panel_intensity);

  // odd drivers count down so their on-time sits at the cycle end
  wire       flip_now = mux_flip_r && driver_addr[0];
  wire [7:0] pwm_pos  = flip_now ? ~pwm_r : pwm_r;
  wire       running  = (state_r == lmi_pkg::LMI_ST_RUN);

  // digit drive: on while the pwm position sits inside the duty window
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      digit_drive_d0 <= 1'b0;
      digit_drive_d1 <= 1'b0;
    end else begin
      digit_drive_d0 <= running && pixel_on_d0 && (pwm_pos < duty0);
      digit_drive_d1 <= running && pixel_on_d1 && (pwm_pos < duty1);
    end
  end

  // status outputs for neighbouring logic
  assign frame_index            = frame_r;
  assign plane_organisation_sel = plane_org_r;
  assign invert_pixels          = invert_r;
  assign shutdown               = shutdown_r;

endmodule : lmi_core

// [bench/lmi_core_monitor.sv]
/* lmi_core_monitor.sv: port-level assertions for lmi_core.
   assumes one clock domain and the async active-high reset. */
`timescale 1ns/1ns
module lmi_core_monitor #(
  parameter bit HAS_RGY  = 1'b1,  // colour bit writable in the bound core
  parameter bit HAS_GREY = 1'b1   // plane bit writable in the bound core
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] current_plane,
  input wire logic       mux_cycle_done,
  input wire logic [1:0] pix_code_d0,
  input wire logic [3:0] frame_index,
  input wire logic       pixel_on_d0,
  input wire logic       digit_drive_d0,
  input wire logic       plane_organisation_sel,
  input wire logic       invert_pixels
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // a write followed by a read of the same offset
  sequence s_wr_rd(logic [7:0] a);
    reg_wr_en && reg_addr == a ##1 reg_addr == a;
  endsequence
  a_digit_wr_read: assert property (s_wr_rd(8'h03) |-> reg_rdata == $past(reg_wdata))
    else $error("digit zero readback wrong");
  // a variant without the feature reads its colour or plane bit back as zero
  a_setup_bits_wr: assert property (s_wr_rd(8'h0d) |-> reg_rdata[7:4] ==
    {HAS_GREY && $past(reg_wdata[7]), HAS_RGY && $past(reg_wdata[6]), $past(reg_wdata[5:4])})
    else $error("setup upper bits readback wrong");
  a_setup_ports: assert property (reg_wr_en && reg_addr == 8'h0d |=>
    plane_organisation_sel == (HAS_GREY && $past(reg_wdata[7])) &&
    invert_pixels == $past(reg_wdata[1]))
    else $error("setup outputs do not follow write");
  a_plane_id_ro: assert property (reg_addr == 8'h0d |-> reg_rdata[3:2] ==
    (plane_organisation_sel ? {1'b1, current_plane[0]} : current_plane))
    else $error("plane id bits wrong");
  a_frame_wrap: assert property (mux_cycle_done && frame_index == 4'hb |=> frame_index == 4'h0)
    else $error("frame index did not wrap");
  a_frame_step: assert property (mux_cycle_done && frame_index < 4'hb |=>
    frame_index == $past(frame_index) + 4'h1)
    else $error("frame index did not advance");
  a_frame_hold: assert property (!mux_cycle_done |=> $stable(frame_index))
    else $error("frame index moved without cycle end");
  a_pixel_full: assert property (pix_code_d0 == 2'b11 && !invert_pixels |=> pixel_on_d0)
    else $error("full code not lit");
  a_pixel_off: assert property (pix_code_d0 == 2'b00 && !invert_pixels |=> !pixel_on_d0)
    else $error("off code lit");
  a_drive_cause: assert property (digit_drive_d0 |-> $past(pixel_on_d0))
    else $error("digit driven for unlit pixel");
endmodule : lmi_core_monitor

bind lmi_core lmi_core_monitor #(.HAS_RGY(HAS_RGY), .HAS_GREY(HAS_GREY)) u_mon (.clock, .rst,
  .reg_wr_en, .reg_addr, .reg_wdata,
  .reg_rdata, .current_plane, .mux_cycle_done, .pix_code_d0, .frame_index, .pixel_on_d0,
  .digit_drive_d0, .plane_organisation_sel, .invert_pixels);

// [bench/lmi_led_panel.sv]
/* lmi_led_panel.sv: behavioural led panel, counts lit clocks per digit.
   assumes digit drives change only on the rising clock edge. */
`timescale 1ns/1ns
module lmi_led_panel (
  input  wire logic clock,
  input  wire logic count_en,   // measurement window open
  input  wire logic drive_d0,   // digit 0 drive
  input  wire logic drive_d1,   // digit 1 drive
  output int        lit_d0 = 0, // lit clocks, digit 0
  output int        lit_d1 = 0  // lit clocks, digit 1
);
  // an unknown drive is not counted as lit, so it shows up as a short count
  always @(posedge clock) begin
    if (count_en) begin
      lit_d0 <= lit_d0 + (drive_d0 === 1'b1);
      lit_d1 <= lit_d1 + (drive_d1 === 1'b1);
    end
  end
endmodule : lmi_led_panel

// [bench/lmi_core_tb.sv]
/* lmi_core_tb.sv: self-checking bench for lmi_core.
   assumes the panel model and the bound monitor are compiled first. */
`timescale 1ns/1ns
module lmi_core_tb;
  logic       clock = 1'b0;  // 20 MHz
  logic       rst = 1'b1;
  logic       reg_wr_en = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:0] rdata_lite;  // read data of the reduced variant
  logic [7:0] panel_intensity = 8'h00, driver_addr = 8'h00;
  logic [1:0] current_plane = 2'h0, grad_geometric = 2'h0;
  logic [1:0] pix_code_d0 = 2'h0, pix_code_d1 = 2'h0;
  logic       mux_sync = 1'b0, mux_cycle_done = 1'b0, cnt_en = 1'b0;
  logic [3:0] frame_index;
  logic       pixel_on_d0, pixel_on_d1, digit_drive_d0, digit_drive_d1;
  logic       plane_organisation_sel, invert_pixels, shutdown;
  int         n_fail = 0, n_tests = 0, lit_d0, lit_d1;

  always #25 clock = ~clock;

  // short pwm step and stagger keep the run brief
  lmi_core #(.TICK_DIV(1), .STAGGER_CYC(2)) dut (.clock, .rst, .reg_wr_en, .reg_addr,
    .reg_wdata, .reg_rdata, .current_plane, .panel_intensity, .driver_addr, .mux_sync,
    .mux_cycle_done, .grad_geometric, .pix_code_d0, .pix_code_d1, .frame_index,
    .pixel_on_d0, .pixel_on_d1, .digit_drive_d0, .digit_drive_d1,
    .plane_organisation_sel, .invert_pixels, .shutdown);
  // reduced variant: colour and plane bits are never stored
  lmi_core #(.HAS_RGY(1'b0), .HAS_GREY(1'b0), .TICK_DIV(1), .STAGGER_CYC(2)) dut_lite (
    .clock, .rst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata(rdata_lite), .current_plane,
    .panel_intensity, .driver_addr, .mux_sync, .mux_cycle_done, .grad_geometric, .pix_code_d0,
    .pix_code_d1, .frame_index(), .pixel_on_d0(), .pixel_on_d1(), .digit_drive_d0(),
    .digit_drive_d1(), .plane_organisation_sel(), .invert_pixels(), .shutdown());
  lmi_led_panel panel (.clock, .count_en(cnt_en), .drive_d0(digit_drive_d0),
    .drive_d1(digit_drive_d1), .lit_d0, .lit_d1);

  task automatic end_sim;
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    @(negedge clock);
    chk("rdata", {4'h0, e}, {4'h0, reg_rdata});
  endtask : rdchk

  // register reset, readback, read-only plane id, unmapped offset
  task automatic t_regs;
    rdchk(8'h03, 8'h00);
    wr(8'h03, 8'hff);
    rdchk(8'h03, 8'hff);
    wr(8'h04, 8'h01);
    rdchk(8'h04, 8'h01);
    @(posedge clock);
    current_plane <= 2'h2;
    wr(8'h0d, 8'h7e);
    rdchk(8'h0d, 8'h7a);
    chk("rdata lite", 12'h03a, {4'h0, rdata_lite});
    chk("setup ports", 12'h002, {9'h000, plane_organisation_sel, invert_pixels, shutdown});
    wr(8'h0d, 8'h80);
    rdchk(8'h0d, 8'h88);
    chk("rdata lite", 12'h008, {4'h0, rdata_lite});
    @(posedge clock);
    current_plane <= 2'h1;
    rdchk(8'h0d, 8'h8c);
    wr(8'h0d, 8'h01);
    rdchk(8'h0d, 8'h05);
    chk("setup ports", 12'h001, {9'h000, plane_organisation_sel, invert_pixels, shutdown});
    wr(8'h0d, 8'h00);
    rdchk(8'h0d, 8'h04);
    rdchk(8'h05, 8'h00);
  endtask : t_regs

  // every code over twelve frames, digit 0 arithmetic, digit 1 geometric
  task automatic t_pat;
    logic [11:0] ar [4] = '{12'h000, 12'h492, 12'hb6d, 12'hfff};
    logic [11:0] ge [4] = '{12'h000, 12'h222, 12'h555, 12'hfff};
    wr(8'h0d, 8'h80);
    grad_geometric <= 2'b10;
    for (int c = 0; c < 4; c++) begin
      pix_code_d0 <= 2'(c);
      pix_code_d1 <= 2'(c);
      for (int f = 0; f < 12; f++) begin
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk("frame", 12'(f), {8'h00, frame_index});
        chk("pix d0", {11'h000, ar[c][f]}, {11'h000, pixel_on_d0});
        chk("pix d1", {11'h000, ge[c][f]}, {11'h000, pixel_on_d1});
        @(posedge clock);
        mux_cycle_done <= 1'b1;
        @(posedge clock);
        mux_cycle_done <= 1'b0;
      end
    end
  endtask : t_pat

  // clocks from sync to first lit drive; pixel held dark before sync
  task automatic lat(output int n);
    pix_code_d0 <= 2'b00;
    repeat (4) @(posedge clock);
    mux_sync <= 1'b1;
    pix_code_d0 <= 2'b11;
    @(posedge clock);
    mux_sync <= 1'b0;
    n = 0;
    // look only at falling edges, where the registered drive has settled
    @(negedge clock);
    while (digit_drive_d0 !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    if (n >= 400) begin
      chk("drive timeout", 12'h000, 12'h001);
      end_sim();
    end
  endtask : lat

  // stagger, flip by address parity, and digit duty as n/256 of panel
  task automatic t_drive;
    int l0, l1;
    panel_intensity <= 8'h80;
    driver_addr <= 8'h03;
    wr(8'h03, 8'h80);
    wr(8'h04, 8'h00);
    wr(8'h0d, 8'h00);
    lat(l0);
    wr(8'h0d, 8'h10);
    lat(l1);
    chk("ripple delay", 12'(l0 + 6), 12'(l1));
    wr(8'h0d, 8'h20);
    lat(l1);
    chk("flip odd", 12'(l0 + 192), 12'(l1));
    @(posedge clock);
    driver_addr <= 8'h02;
    lat(l1);
    chk("flip even", 12'(l0), 12'(l1));
    @(posedge clock);
    cnt_en <= 1'b1;
    repeat (1024) @(posedge clock);
    cnt_en <= 1'b0;
    @(negedge clock);
    chk("lit d0", 12'h100, 12'(lit_d0));
    chk("lit d1", 12'h000, 12'(lit_d1));
  endtask : t_drive

  // reset, then each scenario in turn
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_pat();
    t_drive();
    end_sim();
  end
endmodule : lmi_core_tb
